// >>> mcr_control_regs.sv
// mcu control register bank: id bytes, analog start sequencer, protected lock bits
`timescale 1ns/1ps
module mcr_control_regs
  import mcr_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] MEM_ID   = 8'h94, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'h42, // arbitrary value
  parameter logic [3:0] REV_ID   = 4'h0   // arbitrary value
)(
  input  wire logic                  clk_sys,       // peripheral clock
  input  wire logic                  rst,           // async reset, high
  input  wire logic                  wb_cyc_i,      // bus cycle
  input  wire logic                  wb_stb_i,      // strobe
  input  wire logic                  wb_we_i,       // write
  input  wire logic [MCR_ADDR_W-1:0] wb_adr_i,      // byte address
  input  wire logic [3:0]            wb_sel_i,      // byte enables
  input  wire logic [31:0]           wb_dat_i,      // write data
  output logic      [31:0]           wb_dat_o,      // read data
  output logic                       wb_ack_o,      // acknowledge
  input  wire logic                  adcEnable,     // converter enable, same clock
  input  wire logic                  acEnable,      // comparator enable, same clock
  output logic      [MCR_STAGES-1:0] analogStart,   // staged analog component enables
  output logic                       eventChanLock, // event channels 0..3 frozen
  output logic                       waveExtLock    // timer c0 waveform extension frozen
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  mcr_wb_req_type req;
  logic           ack_r;
  logic [31:0]    rdData_r;
  logic           wrStrobe;
  logic [2:0]     idx;
  logic [7:0]     wrByte;

  assign req      = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i[MCR_ADDR_W-1:2],
                      sel: wb_sel_i, dat: wb_dat_i};
  assign idx      = req.adr;
  assign wrByte   = req.dat[7:0];
  // one-cycle registered ack; the write lands on the edge where the master samples ack high,
  // so a master that drops its request right after that edge never sees a half-done write
  assign wrStrobe = req.cyc && req.stb && req.we && req.sel[0] && ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= req.cyc && req.stb && !ack_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [MCR_DLY_W-1:0] delay_r;
  logic                 evLock_r;
  logic                 wxLock_r;
  logic [2:0]           protCnt_r;
  logic                 protOpen;

  assign protOpen = protCnt_r != 3'h0;

  // reserved bits are dropped on write, so software zeros there cost nothing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      delay_r <= MCR_DLY_RST;
    else if (wrStrobe && idx == MCR_IDX_ANALOG_INIT_CONTROL)
      delay_r <= wrByte[MCR_DLY_LSB +: MCR_DLY_W];
  end

  // protected window: key write opens it for a few cycles, any other protect write closes it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      protCnt_r <= 3'h0;
    else if (wrStrobe && idx == MCR_IDX_PROTECT)
      protCnt_r <= (wrByte == MCR_PROTECT_KEY) ? MCR_PROTECT_CYC : 3'h0;
    else if (protOpen)
      protCnt_r <= protCnt_r - 3'h1;
  end

  // locks only ever set; clearing needs a reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      evLock_r <= MCR_LOCK_RST;
      wxLock_r <= MCR_LOCK_RST;
    end
    else if (wrStrobe && protOpen)
    begin
      if (idx == MCR_IDX_EVLOCK && wrByte[MCR_LOCK_BIT])
        evLock_r <= 1'b1;
      if (idx == MCR_IDX_WXLOCK && wrByte[MCR_LOCK_BIT])
        wxLock_r <= 1'b1;
    end
  end

  assign eventChanLock = evLock_r;
  assign waveExtLock   = wxLock_r;

  // read mux; unmapped slots cannot exist since all eight indices are used
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdData_r <= 32'h0000_0000;
    else if (req.cyc && req.stb && !req.we && !ack_r)
    begin
      unique case (idx)
        MCR_IDX_MAKER:   rdData_r <= {24'h00_0000, MAKER_ID};
        MCR_IDX_MEMSIZE: rdData_r <= {24'h00_0000, MEM_ID};
        MCR_IDX_PARTNUM: rdData_r <= {24'h00_0000, PART_ID};
        MCR_IDX_REV:     rdData_r <= {28'h000_0000, REV_ID};
        MCR_IDX_ANALOG_INIT_CONTROL: rdData_r <= {30'h0000_0000, delay_r};
        MCR_IDX_EVLOCK:  rdData_r <= {31'h0000_0000, evLock_r};
        MCR_IDX_WXLOCK:  rdData_r <= {31'h0000_0000, wxLock_r};
        MCR_IDX_PROTECT: rdData_r <= {31'h0000_0000, protOpen};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog start sequencer, driven only by this port's converter and comparator
  mcr_seq_type seq_r;
  logic        modEnable;
  logic        modEnable_r;
  logic [5:0]  spacing;
  logic [5:0]  gapCnt_r;
  logic [1:0]  stage_r;

  assign modEnable = adcEnable || acEnable;

  always_comb
  begin
    unique case (delay_r)
      MCR_DLY_2:  spacing = MCR_SPC_2;
      MCR_DLY_8:  spacing = MCR_SPC_8;
      MCR_DLY_32: spacing = MCR_SPC_32;
      default:    spacing = 6'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      modEnable_r <= 1'b0;
    else
      modEnable_r <= modEnable;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      seq_r       <= MCR_IDLE;
      gapCnt_r    <= 6'h00;
      stage_r     <= 2'h0;
      analogStart <= '0;
    end
    else if (!modEnable)
    begin
      seq_r       <= MCR_IDLE;
      analogStart <= '0;
    end
    else
    begin
      unique case (seq_r)
        MCR_IDLE:
          if (!modEnable_r)
          begin
            if (delay_r == MCR_DLY_NONE)
            begin
              analogStart <= '1; // direct start
              seq_r       <= MCR_DONE;
            end
            else
            begin
              analogStart <= 3'b001; // first component now
              stage_r     <= 2'h1;
              gapCnt_r    <= spacing - 6'h01;
              seq_r       <= MCR_WAIT;
            end
          end
        MCR_WAIT:
          if (gapCnt_r == 6'h00)
          begin
            analogStart[stage_r] <= 1'b1;
            stage_r  <= stage_r + 2'h1;
            gapCnt_r <= spacing - 6'h01;
            if (stage_r == 2'(MCR_STAGES - 1))
              seq_r <= MCR_DONE;
          end
          else
            gapCnt_r <= gapCnt_r - 6'h01;
        MCR_DONE: ;
        default:  seq_r <= MCR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  lock_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(evLock_r) |=> evLock_r [*8])
    else $error("event lock dropped");

  lock_protect_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(wxLock_r) |-> $past(protOpen))
    else $error("waveform lock set outside window");

  maker_fixed_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ack_r && !req.we && $past(idx) == MCR_IDX_MAKER) |-> wb_dat_o == {24'h00_0000, MAKER_ID})
    else $error("maker id changed");

  rev_reserved_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ack_r && !req.we && $past(idx) == MCR_IDX_REV) |-> wb_dat_o[31:4] == 28'h000_0000)
    else $error("revision reserved bits set");

  direct_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    (modEnable && !modEnable_r && delay_r == MCR_DLY_NONE && seq_r == MCR_IDLE) |=> analogStart == 3'b111)
    else $error("direct start late");

  stagger_8_a: assert property (@(posedge clk_sys) disable iff (rst)
    (modEnable && !modEnable_r && delay_r == MCR_DLY_8 && seq_r == MCR_IDLE)
      ##1 (modEnable && delay_r == MCR_DLY_8) [*8] |=> analogStart == 3'b011)
    else $error("second stage not at 8 cycles");

  stagger_2_a: assert property (@(posedge clk_sys) disable iff (rst)
    (modEnable && !modEnable_r && delay_r == MCR_DLY_2 && seq_r == MCR_IDLE)
      |=> analogStart == 3'b001 ##1 (!modEnable_r || analogStart == 3'b001)
      ##1 (!modEnable_r || !$past(modEnable_r) || analogStart == 3'b011))
    else $error("two cycle spacing wrong");

  stage_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    analogStart[2] |-> analogStart[1] && analogStart[0])
    else $error("stages out of order");

  ack_single_a: assert property (@(posedge clk_sys) disable iff (rst)
    ack_r |=> !ack_r)
    else $error("ack longer than one cycle");

endmodule : mcr_control_regs

// >>> mcr_pkg.sv
// package: register map, field layout and timing constants of the mcu control register bank
package mcr_pkg;

  // register indices (no printed offsets; chosen word slots)
  localparam logic [2:0] MCR_IDX_MAKER   = 3'h0;
  localparam logic [2:0] MCR_IDX_MEMSIZE = 3'h1;
  localparam logic [2:0] MCR_IDX_PARTNUM = 3'h2;
  localparam logic [2:0] MCR_IDX_REV     = 3'h3;
  localparam logic [2:0] MCR_IDX_ANALOG_INIT_CONTROL = 3'h4;
  localparam logic [2:0] MCR_IDX_EVLOCK  = 3'h5;
  localparam logic [2:0] MCR_IDX_WXLOCK  = 3'h6;
  localparam logic [2:0] MCR_IDX_PROTECT = 3'h7;
  localparam int         MCR_ADDR_W      = 5;

  // field positions
  localparam int MCR_DLY_LSB  = 0;
  localparam int MCR_DLY_W    = 2;
  localparam int MCR_LOCK_BIT = 0;
  localparam int MCR_REV_W    = 4;

  // reset values
  localparam logic [1:0] MCR_DLY_RST  = 2'h0;
  localparam logic       MCR_LOCK_RST = 1'b0;

  // unlock key written to the protect register opens a short protected window
  localparam logic [7:0] MCR_PROTECT_KEY = 8'hD8;
  localparam logic [2:0] MCR_PROTECT_CYC = 3'h4;

  // start delay codes and their spacings in peripheral clock cycles
  localparam logic [1:0] MCR_DLY_NONE = 2'b00;
  localparam logic [1:0] MCR_DLY_2    = 2'b01;
  localparam logic [1:0] MCR_DLY_8    = 2'b10;
  localparam logic [1:0] MCR_DLY_32   = 2'b11;
  localparam logic [5:0] MCR_SPC_2    = 6'h02;
  localparam logic [5:0] MCR_SPC_8    = 6'h08;
  localparam logic [5:0] MCR_SPC_32   = 6'h20;
  localparam int         MCR_STAGES   = 3;

  typedef struct packed {
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [MCR_ADDR_W-1:2] adr;
    logic [3:0]            sel;
    logic [31:0]           dat;
  } mcr_wb_req_type;

  typedef enum logic [2:0] {
    MCR_IDLE = 3'b001,
    MCR_WAIT = 3'b010,
    MCR_DONE = 3'b100
  } mcr_seq_type;

endpackage : mcr_pkg

// >>> testbench.sv
// self-checking bench for the mcu control register bank
`timescale 1ns/1ps
module testbench;
  import mcr_pkg::*;
  localparam logic [7:0] MK_ID = 8'h3C; // arbitrary value
  localparam logic [7:0] MS_ID = 8'h71; // arbitrary value
  localparam logic [7:0] PN_ID = 8'h2B; // arbitrary value
  localparam logic [3:0] RV_ID = 4'h2;  // arbitrary value
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic                  wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [MCR_ADDR_W-1:0] wbAdr = '0;
  logic [3:0]            wbSel = '0;
  logic [31:0]           wbDatW = '0, wbDatR, rdat;
  logic                  wbAck, eventChanLock, waveExtLock;
  logic                  adcEnable = 1'b0, acEnable = 1'b0;
  logic [MCR_STAGES-1:0] analogStart;
  int                    failures = 0, checked = 0, cycles = 0;
  always #2 clk_sys = ~clk_sys;
  mcr_control_regs #(.MAKER_ID(MK_ID), .MEM_ID(MS_ID), .PART_ID(PN_ID), .REV_ID(RV_ID)) mcr_control_regs_i (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .adcEnable(adcEnable), .acEnable(acEnable), .analogStart(analogStart),
    .eventChanLock(eventChanLock), .waveExtLock(waveExtLock));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // called just after a rising edge; ends one idle cycle later, on an edge
  task automatic wb_cycle(input logic wr, input logic [4:0] adr, input logic [3:0] sel, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= wr;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= d;
    do @(posedge clk_sys); while (wbAck !== 1'b1);
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_cycle
  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    wb_cycle(1'b1, adr, 4'h1, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [4:0] adr);
    wb_cycle(1'b0, adr, 4'hF, 32'h0);
  endtask : rd
  task automatic seq_test(input logic [1:0] code, input int n, input logic useAc);
    int t0, t1, t2;
    t0 = -1;
    t1 = -1;
    t2 = -1;
    wr(5'h10, {6'h0, code});
    if (useAc)
      acEnable <= 1'b1;
    else
      adcEnable <= 1'b1;
    for (int c = 1; c <= 80; c++)
    begin
      @(posedge clk_sys);
      #1;
      if (t0 < 0 && analogStart[0] === 1'b1) t0 = c;
      if (t1 < 0 && analogStart[1] === 1'b1) t1 = c;
      if (t2 < 0 && analogStart[2] === 1'b1) t2 = c;
    end
    check("first stage start", 32'(t0), 32'h1);
    check("stage spacing 1", 32'(t1 - t0), 32'(n));
    check("stage spacing 2", 32'(t2 - t1), 32'(n));
    @(posedge clk_sys);
    adcEnable <= 1'b0;
    acEnable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("stages off", 32'(analogStart), 32'h0);
  endtask : seq_test
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wr(5'h00, 8'hFF);
    rd(5'h00); check("maker id", rdat, {24'h0, MK_ID});
    rd(5'h03); check("maker id alias", rdat, {24'h0, MK_ID});
    rd(5'h04); check("memory size id", rdat, {24'h0, MS_ID});
    rd(5'h08); check("part number id", rdat, {24'h0, PN_ID});
    wr(5'h0C, 8'hFF);
    rd(5'h0C); check("revision", rdat, {28'h0, RV_ID});
    rd(5'h10); check("delay reset", rdat, 32'h0);
    seq_test(2'b00, 0, 1'b0);
    seq_test(2'b01, 2, 1'b1);
    seq_test(2'b10, 8, 1'b0);
    seq_test(2'b11, 32, 1'b1); // longest spacing the field offers
    wb_cycle(1'b1, 5'h10, 4'h0, 32'h1);
    rd(5'h10); check("delay sel masked", rdat, 32'h3);
    // unprotected lock writes must leave both locks open
    wr(5'h14, 8'h01);
    wr(5'h18, 8'h01);
    rd(5'h14); check("event lock unprotected", rdat, 32'h0);
    check("event lock pin", 32'(eventChanLock), 32'h0);
    check("wave lock pin", 32'(waveExtLock), 32'h0);
    wr(5'h1C, MCR_PROTECT_KEY);
    wr(5'h14, 8'h01);
    rd(5'h14); check("event lock set", rdat, 32'h1);
    check("event lock pin set", 32'(eventChanLock), 32'h1);
    check("wave lock untouched", 32'(waveExtLock), 32'h0);
    wr(5'h1C, MCR_PROTECT_KEY);
    wr(5'h18, 8'h01);
    rd(5'h18); check("wave lock set", rdat, 32'h1);
    check("wave lock pin set", 32'(waveExtLock), 32'h1);
    wr(5'h1C, MCR_PROTECT_KEY);
    wr(5'h14, 8'h00);
    rd(5'h14); check("event lock sticky", rdat, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("locks after reset", {30'h0, eventChanLock, waveExtLock}, 32'h0);
    rd(5'h10); check("delay after reset", rdat, 32'h0);
    // a lock write after the protected window has run out must be ignored
    wr(5'h1C, MCR_PROTECT_KEY);
    repeat (4) @(posedge clk_sys);
    wr(5'h18, 8'h01);
    check("wave lock after window", 32'(waveExtLock), 32'h0);
    end_of_test();
  end
endmodule : testbench
